// ---- logic/acs_sequencer.sv ----
// Conversion sequencer with two-wire serial slave, result hold and shared pin
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer
#(
  parameter logic [6:0] DEV_ADDR = acs_pkg::DEV_ADDR_DEFAULT
)
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic mod_bit_i,
  output logic alert_rdy_o
);
  acs_conv_if conv ();

  acs_filter u_filter
  (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .mod_bit_i(mod_bit_i),
    .conv(conv.filt)
  );

  logic [2:0] scl_s_q;
  logic [2:0] sda_s_q;
  logic scl_f_q;
  logic sda_f_q;
  logic scl_rise, scl_fall, bus_start, bus_stop;

  // Three-stage sampling; a level is taken once stages two and three agree
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
    end
    else
    begin
      scl_s_q <= {scl_s_q[1:0], scl_i};
      sda_s_q <= {sda_s_q[1:0], sda_i};
      if (scl_s_q[1] == scl_s_q[2])
      begin
        scl_f_q <= scl_s_q[2];
      end
      if (sda_s_q[1] == sda_s_q[2])
      begin
        sda_f_q <= sda_s_q[2];
      end
    end
  end

  assign scl_rise = scl_s_q[1] == scl_s_q[2] && scl_s_q[2] && !scl_f_q;
  assign scl_fall = scl_s_q[1] == scl_s_q[2] && !scl_s_q[2] && scl_f_q;
  assign bus_start = sda_s_q[1] == sda_s_q[2] && !sda_s_q[2] && sda_f_q && scl_f_q;
  assign bus_stop = sda_s_q[1] == sda_s_q[2] && sda_s_q[2] && !sda_f_q && scl_f_q;

  acs_pkg::acs_link_e st_q;
  logic [3:0] bit_q;
  logic [1:0] idx_q;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic [7:0] ptr_q;
  logic [7:0] msb_q;
  logic sda_oe_q, ours_q, nack_q, lsb_q;
  logic [15:0] snap_q;
  logic [15:0] cfg_q;
  logic [15:0] thr_q;
  logic [15:0] result_q;
  logic cfg_wr, res_rd;
  logic [7:0] rd_byte;

  // Pointer-selected read word; result snapshot keeps both bytes coherent
  always_comb
  begin
    if (ptr_q == acs_pkg::PTR_CONFIG)
    begin
      rd_byte = lsb_q ? cfg_q[7:0] : cfg_q[15:8];
    end
    else if (ptr_q == acs_pkg::PTR_THRESH)
    begin
      rd_byte = lsb_q ? thr_q[7:0] : thr_q[15:8];
    end
    else
    begin
      rd_byte = lsb_q ? snap_q[7:0] : result_q[15:8];
    end
  end

  assign res_rd = scl_fall && st_q == acs_pkg::ACS_READ && bit_q == 4'h8 && !nack_q
    && !lsb_q && ptr_q == acs_pkg::PTR_RESULT;

  // Serial slave: bits in on rising clock, drive changes on falling clock, except the release on a start or stop
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      st_q <= acs_pkg::ACS_IDLE;
      bit_q <= 4'h0;
      idx_q <= 2'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= acs_pkg::PTR_RESULT;
      msb_q <= 8'h00;
      sda_oe_q <= 1'b0;
      ours_q <= 1'b0;
      nack_q <= 1'b0;
      lsb_q <= 1'b0;
      snap_q <= 16'h0000;
      cfg_q <= acs_pkg::CFG_RESET;
      thr_q <= acs_pkg::THRESH_RESET;
    end
    else if (bus_start)
    begin
      st_q <= acs_pkg::ACS_ADDR;
      bit_q <= 4'hf; // The falling clock that ends the start wraps this to zero
      idx_q <= 2'h0;
      sda_oe_q <= 1'b0;
      nack_q <= 1'b0;
      lsb_q <= 1'b0;
    end
    else if (bus_stop)
    begin
      st_q <= acs_pkg::ACS_IDLE;
      sda_oe_q <= 1'b0;
    end
    else if (scl_rise && st_q != acs_pkg::ACS_IDLE)
    begin
      if (bit_q < 4'h8)
      begin
        sh_q <= {sh_q[6:0], sda_f_q};
      end
      else if (st_q == acs_pkg::ACS_READ && !ours_q && sda_s_q[2])
      begin
        nack_q <= 1'b1;
      end
    end
    else if (scl_fall && st_q != acs_pkg::ACS_IDLE)
    begin
      if (bit_q == 4'h7)
      begin
        bit_q <= 4'h8;
        ours_q <= 1'b0;
        sda_oe_q <= 1'b0;
        if (st_q == acs_pkg::ACS_ADDR)
        begin
          if (sh_q[7:1] == DEV_ADDR)
          begin
            ours_q <= 1'b1;
            sda_oe_q <= 1'b1;
            st_q <= sh_q[0] ? acs_pkg::ACS_READ : acs_pkg::ACS_WRITE;
          end
          else
          begin
            st_q <= acs_pkg::ACS_IDLE;
          end
        end
        else if (st_q == acs_pkg::ACS_WRITE)
        begin
          ours_q <= 1'b1;
          sda_oe_q <= 1'b1;
          idx_q <= idx_q == 2'h3 ? 2'h3 : idx_q + 2'h1;
          if (idx_q == 2'h0)
          begin
            ptr_q <= sh_q;
          end
          else if (idx_q == 2'h1)
          begin
            msb_q <= sh_q;
          end
          else if (idx_q == 2'h2 && ptr_q == acs_pkg::PTR_CONFIG)
          begin
            cfg_q <= {msb_q, sh_q};
          end
          else if (idx_q == 2'h2 && ptr_q == acs_pkg::PTR_THRESH)
          begin
            thr_q <= {msb_q, sh_q};
          end
        end
      end
      else if (bit_q == 4'h8)
      begin
        bit_q <= 4'h0;
        ours_q <= 1'b0;
        if (st_q == acs_pkg::ACS_READ && !nack_q)
        begin
          // Open drain: enable only while a zero goes out
          tx_q <= {rd_byte[6:0], 1'b0};
          sda_oe_q <= !rd_byte[7];
          lsb_q <= !lsb_q;
          if (res_rd)
          begin
            snap_q <= result_q;
          end
        end
        else
        begin
          sda_oe_q <= 1'b0;
          if (st_q == acs_pkg::ACS_READ)
          begin
            st_q <= acs_pkg::ACS_IDLE;
          end
        end
      end
      else
      begin
        bit_q <= bit_q + 4'h1;
        if (st_q == acs_pkg::ACS_READ)
        begin
          sda_oe_q <= !tx_q[7];
          tx_q <= {tx_q[6:0], 1'b0};
        end
      end
    end
  end

  assign cfg_wr = scl_fall && st_q == acs_pkg::ACS_WRITE && bit_q == 4'h7
    && idx_q == 2'h2 && ptr_q == acs_pkg::PTR_CONFIG;
  assign sda_o = 1'b0;
  assign sda_oe_o = sda_oe_q;

  acs_pkg::acs_seq_e seq_q;
  logic start_q;
  logic start_req;
  logic single;
  logic rdy_q;
  logic pin_q;

  assign single = cfg_q[acs_pkg::CFG_SINGLE_BIT];
  // Shutdown start comes from a config write; continuous restarts on each done
  assign start_req = (seq_q == acs_pkg::ACS_SHUTDOWN && cfg_wr)
    || (seq_q == acs_pkg::ACS_RUN && conv.done && !single);

  // Sequencer: shutdown draws no filter activity until a request arrives
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      seq_q <= acs_pkg::ACS_SHUTDOWN;
      start_q <= 1'b0;
      result_q <= 16'h0000;
    end
    else
    begin
      start_q <= start_req;
      case (seq_q)
        acs_pkg::ACS_SHUTDOWN:
        begin
          if (start_req)
          begin
            seq_q <= acs_pkg::ACS_RUN;
          end
        end
        acs_pkg::ACS_RUN:
        begin
          if (conv.done && single)
          begin
            seq_q <= acs_pkg::ACS_SHUTDOWN;
          end
        end
        default: seq_q <= acs_pkg::ACS_SHUTDOWN;
      endcase
      if (conv.done)
      begin
        result_q <= {conv.code, 4'h0};
      end
    end
  end

  assign conv.start = start_q;
  assign conv.rate = cfg_q[acs_pkg::CFG_RATE_LSB +: 3];

  // Shared pin; a fresh result wins over the read that clears ready
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      rdy_q <= 1'b0;
      pin_q <= 1'b0;
    end
    else
    begin
      rdy_q <= conv.done || (rdy_q && !res_rd);
      if (cfg_q[acs_pkg::CFG_PINSEL_BIT])
      begin
        pin_q <= conv.done || (rdy_q && !res_rd);
      end
      else
      begin
        pin_q <= $signed(result_q[15:4]) > $signed(thr_q[15:4]);
      end
    end
  end

  assign alert_rdy_o = pin_q;

  property p_single_shutdown;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (seq_q == acs_pkg::ACS_RUN && conv.done && single) |=> seq_q == acs_pkg::ACS_SHUTDOWN
        && !conv.start;
  endproperty
  a_single_shutdown: assert property (p_single_shutdown) else $error("no shutdown");

  property p_cont_restart;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (seq_q == acs_pkg::ACS_RUN && conv.done && !single) |=> conv.start;
  endproperty
  a_cont_restart: assert property (p_cont_restart) else $error("no restart");

  property p_result_update;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      conv.done |=> result_q[15:4] == $past(conv.code) ##1 $stable(result_q) || conv.done;
  endproperty
  a_result_update: assert property (p_result_update) else $error("result not held");

  property p_cfg_start;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (seq_q == acs_pkg::ACS_SHUTDOWN && cfg_wr) |=> conv.start && seq_q == acs_pkg::ACS_RUN;
  endproperty
  a_cfg_start: assert property (p_cfg_start) else $error("config write did not start");

  property p_rate_follow;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      conv.start |-> conv.rate == cfg_q[acs_pkg::CFG_RATE_LSB +: 3];
  endproperty
  a_rate_follow: assert property (p_rate_follow) else $error("wrong rate");

  property p_ready_pin;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (conv.done && cfg_q[acs_pkg::CFG_PINSEL_BIT]) |=> alert_rdy_o;
  endproperty
  a_ready_pin: assert property (p_ready_pin) else $error("ready not shown");

  property p_msb_first;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      res_rd |=> lsb_q && snap_q == $past(result_q);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("byte order broken");

  property p_sda_drive;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      $rose(sda_oe_q) |-> $past(scl_fall);
  endproperty
  a_sda_drive: assert property (p_sda_drive) else $error("drive while clock high");
endmodule : acs_sequencer
`default_nettype wire

// ---- logic/acs_pkg.sv ----
// Shared constants for the conversion sequencer and its filter
// Contract
// - Two conversion modes only, single-shot or continuous, chosen by the config register.
// - Single-shot: one conversion per request, result stored in the result register.
// - After a single-shot conversion the sequencer returns to shutdown until requested.
// - Continuous: a new conversion starts right after the previous one finishes.
// - Continuous conversions run at the programmed data rate.
// - Result register always readable and holds only the last completed conversion.
// - Result is a 12-bit code derived by filtering the modulator bitstream.
// - Shared pin shows comparator alert or conversion ready, per configuration.
// - Master drives the serial clock; device only samples it and shifts data.
// - Write: address with write bit, pointer byte, then two data bytes.
// - Result reads return most significant byte first, then least significant.
package acs_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned DECIM = 2048;
  // Data rates in samples per second, indexed by the config rate field
  localparam int unsigned SPS_0 = 128;
  localparam int unsigned SPS_1 = 250;
  localparam int unsigned SPS_2 = 490;
  localparam int unsigned SPS_3 = 920;
  localparam int unsigned SPS_4 = 1600;
  localparam int unsigned SPS_5 = 2400;
  localparam int unsigned SPS_6 = 3300;
  // Register pointers
  localparam logic [7:0] PTR_RESULT = 8'h00;
  localparam logic [7:0] PTR_CONFIG = 8'h01;
  localparam logic [7:0] PTR_THRESH = 8'h02;
  // Config field positions
  localparam int unsigned CFG_SINGLE_BIT = 8;
  localparam int unsigned CFG_RATE_LSB = 5;
  localparam int unsigned CFG_PINSEL_BIT = 0;
  localparam logic [15:0] CFG_RESET = 16'h0180;
  localparam logic [15:0] THRESH_RESET = 16'h7ff0;
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h48;
  typedef enum logic [1:0] {ACS_IDLE, ACS_ADDR, ACS_WRITE, ACS_READ} acs_link_e;
  typedef enum logic {ACS_SHUTDOWN, ACS_RUN} acs_seq_e;
endpackage : acs_pkg

// ---- logic/acs_conv_if.sv ----
// Conversion request and result carrier between sequencer and filter
`timescale 1ns/1ps
`default_nettype none
interface acs_conv_if;
  logic start;
  logic [2:0] rate;
  logic done;
  logic [11:0] code;
  modport seq (output start, output rate, input done, input code);
  modport filt (input start, input rate, output done, output code);
endinterface : acs_conv_if
`default_nettype wire

// ---- logic/acs_filter.sv ----
// Decimating counter filter turning the modulator bitstream into a 12-bit code
`timescale 1ns/1ps
`default_nettype none
module acs_filter
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic mod_bit_i,
  acs_conv_if.filt conv
);
  // Clock cycles between bitstream samples so that DECIM samples span one period
  function automatic logic [8:0] acs_interval(input logic [2:0] r);
    int unsigned sps;
    case (r)
      3'h0: sps = acs_pkg::SPS_0;
      3'h1: sps = acs_pkg::SPS_1;
      3'h2: sps = acs_pkg::SPS_2;
      3'h3: sps = acs_pkg::SPS_3;
      3'h4: sps = acs_pkg::SPS_4;
      3'h5: sps = acs_pkg::SPS_5;
      default: sps = acs_pkg::SPS_6;
    endcase
    return 9'(acs_pkg::CLK_HZ / (sps * acs_pkg::DECIM));
  endfunction : acs_interval

  logic busy_q;
  logic [8:0] ivl_q;
  logic [8:0] tick_q;
  logic [11:0] nsmp_q;
  logic [11:0] ones_q;
  logic done_q;
  logic [11:0] code_q;
  logic [12:0] twice;
  logic last;

  // Doubled ones count, including the sample taken on the final tick
  assign twice = {ones_q, 1'b0} + {11'h000, mod_bit_i, 1'b0};
  assign last = busy_q && tick_q == 9'h001 && nsmp_q == 12'(acs_pkg::DECIM - 1);

  // Sample pacing; interval fixed at start so a rate change never splits a conversion
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      busy_q <= 1'b0;
      ivl_q <= 9'h001;
      tick_q <= 9'h001;
      nsmp_q <= 12'h000;
      ones_q <= 12'h000;
    end
    else if (conv.start && !busy_q)
    begin
      busy_q <= 1'b1;
      ivl_q <= acs_interval(conv.rate);
      tick_q <= acs_interval(conv.rate);
      nsmp_q <= 12'h000;
      ones_q <= 12'h000;
    end
    else if (busy_q)
    begin
      if (tick_q == 9'h001)
      begin
        tick_q <= ivl_q;
        ones_q <= ones_q + {11'h000, mod_bit_i};
        nsmp_q <= nsmp_q + 12'h001;
        if (last)
        begin
          busy_q <= 1'b0;
        end
      end
      else
      begin
        tick_q <= tick_q - 9'h001;
      end
    end
  end

  // Code = 2*ones - DECIM, clamped to the signed 12-bit range
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      done_q <= 1'b0;
      code_q <= 12'h000;
    end
    else
    begin
      done_q <= last;
      if (last)
      begin
        if (twice >= 13'h1000)
        begin
          code_q <= 12'h7ff;
        end
        else
        begin
          code_q <= 12'(twice + 13'h0800);
        end
      end
    end
  end

  assign conv.done = done_q;
  assign conv.code = code_q;

  property p_no_early_done;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (conv.start && !busy_q) |=> !done_q [*8];
  endproperty
  a_no_early_done: assert property (p_no_early_done) else $error("done too soon");

  property p_done_after_busy;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      done_q |-> $past(busy_q) && !busy_q;
  endproperty
  a_done_after_busy: assert property (p_done_after_busy) else $error("done without run");
endmodule : acs_filter
`default_nettype wire

// ---- bench/acs_i2c_master.sv ----
// Two-wire bus master model that owns the serial clock and pulls the data line
`timescale 1ns/1ps
`default_nettype none
module acs_i2c_master
(
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_pull_o
);
  // Clock stands high between frames; only this side ever moves it
  initial
  begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end

  // Start: data falls while the clock is high
  task automatic start_c();
    sda_pull_o = 1'b1;
    #80;
    scl_o = 1'b0;
  endtask : start_c

  // Stop: data rises while the clock is high, then the bus is left idle
  task automatic stop_c();
    #40;
    sda_pull_o = 1'b1;
    #40;
    scl_o = 1'b1;
    #80;
    sda_pull_o = 1'b0;
    #80;
  endtask : stop_c

  // One 160 ns slot; data moves mid-low so the device sees it well before the rise
  task automatic slot(input logic b, output logic s);
    #40;
    sda_pull_o = ~b;
    #40;
    scl_o = 1'b1;
    s = sda_i;
    #80;
    scl_o = 1'b0;
  endtask : slot

  // Byte out, most significant bit first; ack is 1 when the device pulled low
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      slot(b[i], s);
    slot(1'b1, s);
    ack = ~s;
  endtask : wr_byte

  // Byte in; last gives a not-acknowledge so the device stops sending
  task automatic rd_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      slot(1'b1, s);
      b[i] = s;
    end
    slot(last, s);
  endtask : rd_byte
endmodule : acs_i2c_master
`default_nettype wire

// ---- bench/adc_conversion_sequencer_tb.sv ----
// Self-checking bench for the conversion sequencer through its serial port and shared pin
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer_tb;
  localparam logic [6:0] DEV = acs_pkg::DEV_ADDR_DEFAULT;
  logic ref_clk_i;
  logic reset_n_i;
  logic mod_bit_i;
  logic scl;
  logic sda_pull;
  logic sda_o;
  logic sda_oe;
  logic alert;
  logic sda_line;
  int err_count = 0;
  int cmp_count = 0;
  logic [15:0] v;
  int n;
  realtime t0;

  // Pulled-up data line: low whenever either party pulls it
  assign sda_line = ~(sda_pull | (sda_oe & ~sda_o));

  acs_sequencer dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .scl_i(scl),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe), .mod_bit_i(mod_bit_i),
    .alert_rdy_o(alert));
  acs_i2c_master m (.sda_i(sda_line), .scl_o(scl), .sda_pull_o(sda_pull));

  // 100 MHz clock
  initial
  begin
    ref_clk_i = 1'b0;
  end
  always #5 ref_clk_i = ~ref_clk_i;

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask : check

  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  // Full write: address, pointer, then both data bytes, all acknowledged
  task automatic write_reg(input logic [7:0] ptr, input logic [15:0] d);
    logic [3:0] a;
    m.start_c();
    m.wr_byte({DEV, 1'b0}, a[3]);
    m.wr_byte(ptr, a[2]);
    m.wr_byte(d[15:8], a[1]);
    m.wr_byte(d[7:0], a[0]);
    m.stop_c();
    check({12'h000, a}, 16'h000f);
  endtask : write_reg

  // Pointer set, then a two-byte read most significant byte first
  task automatic read_reg(input logic [7:0] ptr, output logic [15:0] d);
    logic [2:0] a;
    m.start_c();
    m.wr_byte({DEV, 1'b0}, a[2]);
    m.wr_byte(ptr, a[1]);
    m.stop_c();
    m.start_c();
    m.wr_byte({DEV, 1'b1}, a[0]);
    m.rd_byte(1'b0, d[15:8]);
    m.rd_byte(1'b1, d[7:0]);
    m.stop_c();
    check({13'h0000, a}, 16'h0007);
  endtask : read_reg

  // Bounded wait for the shared pin to reach a level
  task automatic wait_pin(input logic lvl);
    n = 0;
    while (alert !== lvl && n < 30000)
    begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    check({15'h0000, alert}, {15'h0000, lvl});
  endtask : wait_pin

  // Reset state, register defaults and a foreign address left unanswered
  task automatic t_reset();
    logic a;
    check({14'h0000, sda_oe, alert}, 16'h0000);
    read_reg(acs_pkg::PTR_CONFIG, v);
    check(v, acs_pkg::CFG_RESET);
    read_reg(acs_pkg::PTR_THRESH, v);
    check(v, acs_pkg::THRESH_RESET);
    read_reg(acs_pkg::PTR_RESULT, v);
    check(v, 16'h0000);
    m.start_c();
    m.wr_byte({DEV ^ 7'h01, 1'b0}, a);
    m.stop_c();
    check({15'h0000, a}, 16'h0000);
    $display("test reset done");
  endtask : t_reset

  // Single shot at the fastest rate, ready mode, then stays in shutdown
  task automatic t_single();
    mod_bit_i = 1'b1;
    write_reg(acs_pkg::PTR_CONFIG, 16'h01c1);
    wait_pin(1'b1);
    check({15'h0000, n < 28000}, 16'h0000);
    read_reg(acs_pkg::PTR_RESULT, v);
    check(v, 16'h7ff0);
    check({15'h0000, alert}, 16'h0000);
    write_reg(acs_pkg::PTR_THRESH, 16'h0000);
    repeat (29500) @(posedge ref_clk_i);
    #1;
    check({15'h0000, alert}, 16'h0000);
    $display("test single done");
  endtask : t_single

  // Continuous stream in alert mode; old result stays readable mid-conversion
  task automatic t_cont();
    mod_bit_i = 1'b0;
    write_reg(acs_pkg::PTR_CONFIG, 16'h00c0);
    repeat (4) @(posedge ref_clk_i);
    #1;
    check({15'h0000, alert}, 16'h0001);
    read_reg(acs_pkg::PTR_RESULT, v);
    check(v, 16'h7ff0);
    wait_pin(1'b0);
    t0 = $realtime;
    mod_bit_i = 1'b1;
    read_reg(acs_pkg::PTR_RESULT, v);
    check(v, 16'h8000);
    wait_pin(1'b1);
    n = int'(($realtime - t0) / 10.0);
    check({15'h0000, n > 28632 && n < 28712}, 16'h0001);
    $display("test continuous done");
  endtask : t_cont

  // Main sequence; reset is held for 12 cycles
  initial
  begin
    reset_n_i = 1'b0;
    mod_bit_i = 1'b0;
    repeat (12) @(posedge ref_clk_i);
    #1;
    reset_n_i = 1'b1;
    repeat (4) @(posedge ref_clk_i);
    #1;
    t_reset();
    t_single();
    t_cont();
    end_sim();
  end

  // Watchdog: about twice the expected run of roughly 125k cycles
  initial
  begin
    #2500000;
    err_count++;
    end_sim();
  end
endmodule : adc_conversion_sequencer_tb
`default_nettype wire
